// >>> ssw_supervisor.sv
// Supply supervisor reset generator with watchdog and manual push-button.
// Assumes supply_ok comes from an analog comparator outside; all pins are
// asynchronous and pass two flip-flops. The manual input's pull-up and the
// kick input's floating sense are modelled as an "open" indication per pin.
// Notes on behaviour
// - Reset output is low while supply is bad or manual input is low, and pulses low on any trigger.
// - After supply recovery, watchdog expiry or manual release, reset stays asserted for the hold time.
// - Reset holds for the whole time the manual input is low and for the hold time after release.
// - A kick input that stays at one level for the timeout makes the watchdog expire and assert reset.
// - Every kick edge clears the watchdog timer, and the timer stays cleared while reset is asserted.
// - A floating or tri-stated kick input disables the watchdog so it causes no reset.
// - The active-high reset output is the exact push-pull inverse of the active-low one.
// - Build options select watchdog, manual input, active-high output and open-drain drive.
// - An open manual input reads as high and never causes a reset.
// - A bad supply clears the hold timer, which restarts only once the supply is good again.
// - The watchdog timer starts counting as soon as reset is released.
// - A kick pulse as short as 50 ns is still seen as a valid service.
// - In open-drain form the active-low line is pulled low only during reset, else released.
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor
  import ssw_pkg::*;
#(
  parameter bit HAS_WATCHDOG = 1'b1,
  parameter bit HAS_MANUAL = 1'b1,
  parameter bit HAS_ACTIVE_HIGH = 1'b1,
  parameter bit OPEN_DRAIN = 1'b0,
  parameter int unsigned HOLD_COUNT = HOLD_CYCLES,
  parameter int unsigned WDOG_COUNT = WDOG_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Supply comparator
  input wire logic supply_ok,
  // Manual push-button, with open-pin sense
  input wire logic manual_push_reset_n,
  input wire logic manual_push_open,
  // Watchdog kick, with floating-pin sense
  input wire logic watchdog_kick_in,
  input wire logic watchdog_kick_float,
  // Reset outputs
  output logic sys_reset_n_out,
  output logic sys_reset_n_oe,
  output logic sys_reset_hi
);

  localparam int HW = (HOLD_COUNT > 1) ? $clog2(HOLD_COUNT + 1) : 1;
  localparam int WW = (WDOG_COUNT > 1) ? $clog2(WDOG_COUNT + 1) : 1;
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_COUNT - 1);
  localparam logic [WW-1:0] WDOG_LAST = WW'(WDOG_COUNT - 1);

  // Any state but idle holds the system in reset
  function automatic logic in_reset(input ssw_state_e s);
    return s != SSW_IDLE;
  endfunction : in_reset

  // Refuse builds the counters or the edge detector cannot serve
  if (HOLD_COUNT < 1) begin : g_bad_hold
    $error("ssw_supervisor: HOLD_COUNT must be at least 1");
  end
  if (WDOG_COUNT < 2) begin : g_bad_wdog
    $error("ssw_supervisor: WDOG_COUNT must be at least 2");
  end
  if (KICK_PULSE_CYCLES < 2) begin : g_bad_pulse
    $error("ssw_supervisor: clock too slow for shortest kick pulse");
  end
  if (FLOAT_CYCLES < 2) begin : g_bad_float
    $error("ssw_supervisor: FLOAT_CYCLES must be at least 2");
  end

  // Two-stage synchronisers; stage one read only by stage two
  localparam int NPIN = 5;
  logic [NPIN-1:0] raw_pins;
  wire logic [NPIN-1:0] synced;
  ssw_inputs_s in_s;

  // Pins go straight into the first stage; no gate sits ahead of the flops
  assign raw_pins = {supply_ok, manual_push_reset_n, manual_push_open,
                     watchdog_kick_in, watchdog_kick_float};

  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    logic sync1_reg;
    logic sync2_reg;
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        sync1_reg <= 1'b0;
        sync2_reg <= 1'b0;
      end else begin
        sync1_reg <= raw_pins[i];
        sync2_reg <= sync1_reg;
      end
    end
    assign synced[i] = sync2_reg;
  end

  // An open manual pin reads high, as its pull-up would make it
  assign in_s = '{
    supply_ok: synced[4],
    push_n: synced[3] | synced[2],
    kick: synced[1],
    kick_float: synced[0]
  };

  // Kick sense state
  logic kick_prev_reg, kick_prev_next;
  logic [FLOAT_CYCLES-1:0] float_reg, float_next;
  logic kick_edge;
  logic wdog_enabled;

  always_comb begin
    // 50 ns spans five cycles, so the shortest pulse still shows both edges
    kick_edge = in_s.kick != kick_prev_reg;
    kick_prev_next = in_s.kick;
    // Floating must persist a few cycles; a briefly released driver is not floating
    float_next = {float_reg[FLOAT_CYCLES-2:0], in_s.kick_float};
    wdog_enabled = HAS_WATCHDOG && !(&float_reg);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      kick_prev_reg <= 1'b0;
      float_reg <= '0;
    end else begin
      kick_prev_reg <= kick_prev_next;
      float_reg <= float_next;
    end
  end

  // Reset sequencing state
  ssw_state_e state_reg, state_next;
  logic [HW-1:0] hold_reg, hold_next;
  logic [WW-1:0] wdog_reg, wdog_next;
  logic push_low;
  logic wdog_expire;
  logic level_hold;
  logic assert_now;

  always_comb begin
    // Manual input ignored when omitted at build time
    push_low = HAS_MANUAL && !in_s.push_n;
    // Expiry only counts in idle; the timer sits at zero through any reset
    wdog_expire = wdog_enabled && !in_reset(state_reg) && (wdog_reg == WDOG_LAST);
    level_hold = !in_s.supply_ok || push_low;
    assert_now = level_hold || wdog_expire;
    state_next = state_reg;
    hold_next = hold_reg;
    wdog_next = wdog_reg;
    unique case (state_reg)
      SSW_IDLE: begin
        if (assert_now) begin
          state_next = level_hold ? SSW_HOLD_LOW : SSW_RECOVER;
          hold_next = '0;
          wdog_next = '0;
        end else if (kick_edge || !wdog_enabled) begin
          wdog_next = '0;
        end else begin
          wdog_next = wdog_reg + WW'(1);
        end
      end
      SSW_HOLD_LOW: begin
        hold_next = '0;
        wdog_next = '0;
        if (!level_hold) begin
          state_next = SSW_RECOVER;
        end
      end
      SSW_RECOVER: begin
        wdog_next = '0;
        if (level_hold) begin
          state_next = SSW_HOLD_LOW;
          hold_next = '0;
        end else if (hold_reg == HOLD_LAST) begin
          state_next = SSW_IDLE;
          hold_next = '0;
        end else begin
          hold_next = hold_reg + HW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      // Power-up runs a full hold before the first release
      state_reg <= SSW_HOLD_LOW;
      hold_reg <= '0;
      wdog_reg <= '0;
    end else begin
      state_reg <= state_next;
      hold_reg <= hold_next;
      wdog_reg <= wdog_next;
    end
  end

  // Pin drive follows the next state, so the pins come straight from flops
  ssw_pins_s pins_reg, pins_next;

  always_comb begin
    pins_next.reset_n = !in_reset(state_next);
    // Open drain only sinks; the line is left to its pull-up when released
    pins_next.reset_n_oe = OPEN_DRAIN ? in_reset(state_next) : 1'b1;
    pins_next.reset_hi = HAS_ACTIVE_HIGH && in_reset(state_next);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pins_reg <= '{reset_n: 1'b0, reset_n_oe: 1'b1, reset_hi: HAS_ACTIVE_HIGH};
    end else begin
      pins_reg <= pins_next;
    end
  end

  assign sys_reset_n_out = pins_reg.reset_n;
  assign sys_reset_n_oe = pins_reg.reset_n_oe;
  assign sys_reset_hi = pins_reg.reset_hi;

endmodule : ssw_supervisor
`default_nettype wire

// >>> ssw_pkg.sv
// Package for the supply supervisor with watchdog and push-button reset.
// Assumes a single 100 MHz clock; no software-visible registers.
package ssw_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Reset hold time, in milliseconds
  localparam int unsigned HOLD_TIME_MS = 200;
  localparam int unsigned HOLD_CYCLES = HOLD_TIME_MS * (CLK_HZ / 1000);

  // Watchdog timeout, in milliseconds (1.6 s)
  localparam int unsigned WDOG_TIME_MS = 1600;
  localparam longint unsigned WDOG_CYCLES_L = longint'(WDOG_TIME_MS) * (CLK_HZ / 1000);
  localparam int unsigned WDOG_CYCLES = 32'(WDOG_CYCLES_L);

  // Shortest kick pulse that must be seen, in nanoseconds
  localparam int unsigned KICK_PULSE_NS = 50;
  localparam int unsigned KICK_PULSE_CYCLES = KICK_PULSE_NS / CLK_PERIOD_NS;

  // Cycles a kick input must stay undriven before it counts as floating
  localparam int unsigned FLOAT_CYCLES = 4;

  // Supervisor sequencing states
  typedef enum logic [1:0] {
    SSW_IDLE,
    SSW_HOLD_LOW,
    SSW_RECOVER
  } ssw_state_e;

  // Conditioned inputs after synchronisation
  typedef struct packed {
    logic supply_ok;
    logic push_n;
    logic kick;
    logic kick_float;
  } ssw_inputs_s;

  // Drive for the reset pins
  typedef struct packed {
    logic reset_n;
    logic reset_n_oe;
    logic reset_hi;
  } ssw_pins_s;

endpackage : ssw_pkg

// >>> ssw_supervisor_asserts.sv
// Checker on the supervisor pins.
// Assumes push-pull build with active-high output and hold count of 8 or more.
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Causes
  input wire logic supply_ok,
  input wire logic manual_push_reset_n,
  input wire logic manual_push_open,
  // Reset pins
  input wire logic sys_reset_n_out,
  input wire logic sys_reset_n_oe,
  input wire logic sys_reset_hi
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic o;
  logic ml;
  assign o = sys_reset_n_out;
  assign ml = !manual_push_reset_n && !manual_push_open;
  property p_inv; sys_reset_hi == !o; endproperty
  a_inv: assert property (p_inv) else $error("hi not inverse");
  property p_oe; sys_reset_n_oe; endproperty
  a_oe: assert property (p_oe) else $error("push-pull not driven");
  property p_sfall; $fell(supply_ok) |-> ##[1:6] !o; endproperty
  a_sfall: assert property (p_sfall) else $error("no reset on supply");
  property p_mfall; $rose(ml) |-> ##[1:6] !o; endproperty
  a_mfall: assert property (p_mfall) else $error("no reset on button");
  property p_slow; !supply_ok [*6] |-> !o; endproperty
  a_slow: assert property (p_slow) else $error("reset off, supply low");
  property p_mlow; ml [*6] |-> !o; endproperty
  a_mlow: assert property (p_mlow) else $error("reset off, button low");
  property p_hold; $fell(o) |-> !o [*8]; endproperty
  a_hold: assert property (p_hold) else $error("hold too short");
  property p_rel; $rose(o) |-> $past(supply_ok && !ml, 6); endproperty
  a_rel: assert property (p_rel) else $error("early release");
endmodule : ssw_supervisor_asserts
`default_nettype wire

// >>> ssw_host_model.sv
// Host side: kicks the watchdog with short pulses while enabled.
// Assumes the bench clock; no kicks while held in reset.
`timescale 1ns/1ps
`default_nettype none
module ssw_host_model
  import ssw_pkg::*;
#(
  parameter int unsigned GAP = 20
) (
  // Clock and control
  input wire logic clock,
  input wire logic kick_en,
  input wire logic sys_reset_n_out,
  // Kick line
  output logic watchdog_kick_in
);
  int unsigned cnt = 0;
  // Shortest pulse only, so a slow edge detector is caught out
  always @(posedge clock) begin
    cnt <= (kick_en && sys_reset_n_out) ? (cnt + 1) % GAP : 0;
    watchdog_kick_in <= kick_en && sys_reset_n_out && cnt < KICK_PULSE_CYCLES;
  end
endmodule : ssw_host_model
`default_nettype wire

// >>> ssw_supervisor_tb_top.sv
// Bench: host model kicks, bench drives supply, button and float sense.
// Assumes small hold and timeout counts; low pulses are measured and queued.
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor_tb_top;
  localparam int HOLD = 10;
  localparam int WDOG = 50;
  logic clock = 1'b0, reset_n = 1'b0, supply_ok = 1'b1, kick_en = 1'b0;
  logic manual_push_reset_n = 1'b1, manual_push_open = 1'b0, watchdog_kick_float = 1'b0;
  logic watchdog_kick_in, sys_reset_n_out, sys_reset_n_oe, sys_reset_hi;
  int error_cnt = 0, num_checks = 0, low_cnt = 0, len;
  int exp_q[$]; // Positive: least low time; negative: exact low time
  always #5 clock = ~clock;
  ssw_supervisor #(.HOLD_COUNT(HOLD), .WDOG_COUNT(WDOG)) i_ssw_supervisor (.clock, .reset_n,
    .supply_ok, .manual_push_reset_n, .manual_push_open, .watchdog_kick_in,
    .watchdog_kick_float, .sys_reset_n_out, .sys_reset_n_oe, .sys_reset_hi);
  ssw_host_model i_ssw_host_model (.clock, .kick_en, .sys_reset_n_out, .watchdog_kick_in);
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic check_len(input int exp, input int got);
    num_checks++;
    if (exp < 0 ? got != -exp : got < exp) begin
      error_cnt++;
      $display("ERROR t=%0t exp=%0h got=%0h", $time, exp, got);
    end
  endtask : check_len
  task automatic check_pins(input logic [1:0] exp, input logic [1:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t exp=%0h got=%0h", $time, exp, got);
    end
  endtask : check_pins
  task automatic run(input int n);
    repeat (n) @(posedge clock);
  endtask : run
  // Stray or missing pulses show up as queue mismatches
  always @(posedge clock) begin
    if (reset_n) begin
      check_pins({1'b1, sys_reset_n_out !== 1'b1}, {sys_reset_n_oe, sys_reset_hi});
    end
    if (reset_n && sys_reset_n_out === 1'b0) low_cnt <= low_cnt + 1;
    else if (reset_n && low_cnt != 0) begin
      if (exp_q.size() == 0) check_len(0, -1);
      else check_len(exp_q.pop_front(), low_cnt);
      low_cnt <= 0;
    end
  end
  initial begin
    void'($urandom(26));
    exp_q.push_back(HOLD);
    run(4);
    reset_n <= 1'b1;
    kick_en <= 1'b1;
    run(300);
    exp_q.push_back(-HOLD);
    exp_q.push_back(-HOLD);
    kick_en <= 1'b0;
    run(2 * WDOG + 2 * HOLD + 20);
    kick_en <= 1'b1;
    len = 5 + $urandom % 16;
    exp_q.push_back(len + HOLD - 1);
    manual_push_reset_n <= 1'b0;
    run(len);
    manual_push_reset_n <= 1'b1;
    run(HOLD + 40);
    manual_push_open <= 1'b1;
    manual_push_reset_n <= 1'b0;
    run(60);
    manual_push_open <= 1'b0;
    manual_push_reset_n <= 1'b1;
    exp_q.push_back(20 + HOLD - 1);
    supply_ok <= 1'b0;
    run(10);
    supply_ok <= 1'b1;
    run(4);
    supply_ok <= 1'b0;
    run(6);
    supply_ok <= 1'b1;
    run(HOLD + 40);
    exp_q.push_back(HOLD);
    reset_n <= 1'b0;
    run(4);
    reset_n <= 1'b1;
    run(HOLD + 40);
    kick_en <= 1'b0;
    watchdog_kick_float <= 1'b1;
    run(3 * WDOG);
    if (exp_q.size() != 0 || low_cnt != 0) check_len(0, -1);
    stop_test();
  end
endmodule : ssw_supervisor_tb_top
bind ssw_supervisor ssw_supervisor_asserts i_ssw_supervisor_asserts (.clock, .reset_n,
  .supply_ok, .manual_push_reset_n, .manual_push_open, .sys_reset_n_out, .sys_reset_n_oe,
  .sys_reset_hi);
`default_nettype wire
